// File: verilog/adc_ctrl_defs.vh
// Register offsets, field positions, reset values and codes of the converter control
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH
`define OFS_MODE 8'h00
`define OFS_INPUT_CHANNEL_SELECT 8'h04
`define OFS_CLKPWR 8'h08
`define OFS_TRG0 8'h0C
`define OFS_TRG1 8'h10
`define OFS_TRG2 8'h14
`define OFS_BURST 8'h18
`define OFS_STARTSTOP 8'h20
`define OFS_STATUS 8'h24
`define OFS_IEN 8'h28
`define OFS_DMADATA 8'h2C
`define OFS_COMPARE 8'h70
`define RST_MODE 32'h00000000
`define RST_CLKPWR 16'h0080
`define MODE_WAIT_HI 31
`define MODE_WAIT_LO 24
`define MODE_DMA_EN 17
`define MODE_DMA_TAG 16
`define MODE_BURST_WAIT_COUNT_EN 12
`define MODE_BLEN_HI 10
`define MODE_BLEN_LO 8
`define MODE_ENABLE 7
`define MODE_CMOD_HI 5
`define MODE_CMOD_LO 4
`define MODE_TRG_EN 3
`define MODE_TSRC_HI 2
`define MODE_TSRC_LO 0
`define CP_DAC_OFF 15
`define CP_DIV_HI 14
`define CP_DIV_LO 8
`define CP_PDOWN 7
`define CP_EXTERNAL_CLOCK_SELECT 6
`define CP_INV 5
`define CP_STS_HI 4
`define CP_STS_LO 0
`define SS_STOP 4
`define SS_START 0
`define CMOD_SINGLE 2'b00
`define CMOD_CONT 2'b01
`define CMOD_BURST 2'b11
`define SAMPLE_BASE 6'h02
`define SAMPLE_ALWAYS 5'h1F
`endif

// File: verilog/conv_clock_gen.v
// Conversion clock generator: divider, inversion and external clock select
`timescale 1ns/100ps
module conv_clock_gen #(
	parameter DIV_W = 7
) (
	// Clock and reset
	input wire clock,
	input wire reset_n,
	// Settings
	input wire [DIV_W-1:0] clock_divider,
	input wire divided_clock_invert,
	input wire external_clock_select,
	// External clock pin
	input wire ext_clock_pin,
	// Conversion clock
	output reg conv_tick,
	output reg conv_clk
);
	reg [DIV_W-1:0] cnt_r;
	reg ext_s1_r;
	reg ext_s2_r;
	reg ext_s3_r;
	wire [DIV_W-1:0] half = clock_divider >> 1;
	wire [DIV_W-1:0] high_len = divided_clock_invert ? half :
		clock_divider - half;
	wire [DIV_W-1:0] one = {{(DIV_W-1){1'b0}}, 1'b1};

	////////////////////////////////////////////////////////////////////////
	// External clock passes two flops before the edge detector reads it
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
		end else begin
			ext_s1_r <= ext_clock_pin;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Divider; a divider of one stops the clock, zero passes every edge
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= {DIV_W{1'b0}};
			conv_tick <= 1'b0;
			conv_clk <= 1'b0;
		end else if (external_clock_select) begin
			cnt_r <= {DIV_W{1'b0}};
			conv_tick <= ext_s2_r & ~ext_s3_r;
			conv_clk <= ext_s2_r;
		end else if (clock_divider == {DIV_W{1'b0}}) begin
			cnt_r <= {DIV_W{1'b0}};
			conv_tick <= 1'b1;
			conv_clk <= 1'b1;
		end else if (clock_divider == one) begin
			cnt_r <= {DIV_W{1'b0}};
			conv_tick <= 1'b0;
			conv_clk <= 1'b0;
		end else begin
			cnt_r <= (cnt_r >= clock_divider - one) ? {DIV_W{1'b0}} :
				cnt_r + one;
			conv_tick <= (cnt_r == {DIV_W{1'b0}});
			conv_clk <= (cnt_r < high_len);
		end
	end
endmodule // conv_clock_gen

// File: verilog/trigger_select.v
// Hardware trigger synchroniser, edge detector and source selector
`timescale 1ns/100ps
module trigger_select (
	// Clock and reset
	input wire clock,
	input wire reset_n,
	// Trigger inputs: pin, timer groups 1..3, pwm units 0 and 1
	input wire [5:0] trigger_in,
	input wire [2:0] trigger_source_select,
	// Selected rising edge, one cycle
	output reg trigger_pulse
);
	reg [5:0] s1_r;
	reg [5:0] s2_r;
	reg [5:0] s3_r;
	wire [5:0] rise = s2_r & ~s3_r;

	////////////////////////////////////////////////////////////////////////
	// Two flops ahead of the edge detector; codes 110 and 111 select nothing
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s1_r <= 6'h00;
			s2_r <= 6'h00;
			s3_r <= 6'h00;
			trigger_pulse <= 1'b0;
		end else begin
			s1_r <= trigger_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			trigger_pulse <= (trigger_source_select < 3'h6) &&
				rise[trigger_source_select];
		end
	end
endmodule // trigger_select

// File: verilog/adc_conversion_control.v
// Control logic of one converter unit: registers, sequencer and DMA handshake
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`include "adc_ctrl_defs.vh"
// Overview of operation
// - Burst wait holds each following burst step for count conversion clocks.
// - With DMA on, request per conversion; interrupt only after DMA done.
// - Channel tag sits in bits 3:0 if option set, else bits 19:16.
// - Burst wait enable one inserts wait before conversion; zero inserts none.
// - Burst length 000 means single, 001..111 mean two to eight conversions.
// - Mode 00 single, 01 continuous, 11 burst; bursts start at slot one.
// - Hardware triggers honoured only in single and burst with trigger enable.
// - Trigger source codes: pin, timer groups 1..3, pwm 0, pwm 1.
// - Four-bit channel select routes analog channel N to the converter.
// - Internal conversion clock is system clock over divider; 0 passes, 1 stops.
// - External clock select picks divided clock at 0, external clock at 1.
// - Inversion 0 gives high duty above half, 1 below half, for odd dividers; even dividers give half either way.
// - Power down bit one keeps converter down; control register resets 0x80.
// - Sampling lasts two plus sample time clocks; 11111 keeps sampling on.
// - Start begins a conversion only when enabled; clears next conversion clock.
// - Stop ends conversions after the current one; clears next conversion clock.
// - Burst slot register holds eight four-bit channels, slot one lowest.
module adc_conversion_control #(
	parameter DIV_W = 7,
	parameter RES_W = 12
) (
	// Clock and reset
	input wire clock,
	input wire reset_n,
	// Register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [31:0] reg_rdata,
	// Clock and trigger pins
	input wire ext_clock_pin,
	input wire [5:0] trigger_in,
	// Analog core
	output reg [3:0] core_channel,
	output wire core_sample,
	output reg core_soc,
	output wire core_power_down,
	output wire core_dac_disable,
	output wire core_conv_clk,
	input wire core_eoc,
	input wire [RES_W-1:0] core_result,
	// DMA
	output reg dma_request,
	input wire dma_done,
	output reg [31:0] dma_result_word,
	// Interrupt request
	output wire conversion_irq
);
	localparam S_IDLE = 3'd0;
	localparam S_WAIT = 3'd1;
	localparam S_SAMPLE = 3'd2;
	localparam S_CONV = 3'd3;
	localparam S_NEXT = 3'd4;

	reg [31:0] mode_r;
	reg [3:0] input_channel_select_r;
	reg [15:0] clkpwr_r;
	reg [31:0] trg0_r;
	reg [31:0] trg1_r;
	reg [31:0] trg2_r;
	reg [31:0] slots_r;
	reg [31:0] compare_r;
	reg [4:0] ien_r;
	reg start_r;
	reg stop_r;
	reg [2:0] state_r;
	reg [5:0] count_r;
	reg [7:0] wait_r;
	reg [2:0] step_r;
	reg [RES_W-1:0] result_r;
	reg [3:0] rch_r;
	reg trg_r;
	reg end_r;
	reg ovr_r;
	reg [4:0] irq_r;
	reg by_trigger_r;
	reg stop_pend_r;
	reg trig_pend_r;
	wire conv_tick;
	wire trigger_pulse;

	wire [1:0] cmod = mode_r[`MODE_CMOD_HI:`MODE_CMOD_LO];
	wire [2:0] blen = mode_r[`MODE_BLEN_HI:`MODE_BLEN_LO];
	wire [7:0] burst_wait_count = mode_r[`MODE_WAIT_HI:`MODE_WAIT_LO];
	wire enabled = mode_r[`MODE_ENABLE];
	wire dma_en = mode_r[`MODE_DMA_EN];
	wire [4:0] sts = clkpwr_r[`CP_STS_HI:`CP_STS_LO];
	wire mode_ok = (cmod != 2'b10);
	wire is_burst = (cmod == `CMOD_BURST);
	wire hw_ok = mode_r[`MODE_TRG_EN] && (cmod != `CMOD_CONT);
	wire go = enabled && mode_ok && (start_r ||
		(hw_ok && (trigger_pulse || trig_pend_r)));
	wire wr_status = reg_write && (reg_addr == `OFS_STATUS);
	wire [5:0] sample_len = `SAMPLE_BASE + {1'b0, sts};
	wire last_step = !is_burst || (step_r == blen);

	// Channel of one burst slot
	function [3:0] slot_ch;
		input [31:0] slots;
		input [2:0] idx;
		begin
			slot_ch = slots[{idx, 2'b00} +: 4];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Conversion clock and trigger selection
	conv_clock_gen #(
		.DIV_W(DIV_W)
	) u_clk (
		.clock(clock),
		.reset_n(reset_n),
		.clock_divider(clkpwr_r[`CP_DIV_HI:`CP_DIV_LO]),
		.divided_clock_invert(clkpwr_r[`CP_INV]),
		.external_clock_select(clkpwr_r[`CP_EXTERNAL_CLOCK_SELECT]),
		.ext_clock_pin(ext_clock_pin),
		.conv_tick(conv_tick),
		.conv_clk(core_conv_clk)
	);

	trigger_select u_trg (
		.clock(clock),
		.reset_n(reset_n),
		.trigger_in(trigger_in),
		.trigger_source_select(mode_r[`MODE_TSRC_HI:`MODE_TSRC_LO]),
		.trigger_pulse(trigger_pulse)
	);

	////////////////////////////////////////////////////////////////////////
	// Writable registers; compare and trigger channel words are plain storage
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mode_r <= `RST_MODE;
			input_channel_select_r <= 4'h0;
			clkpwr_r <= `RST_CLKPWR;
			trg0_r <= 32'h00000000;
			trg1_r <= 32'h00000000;
			trg2_r <= 32'h00000000;
			slots_r <= 32'h00000000;
			compare_r <= 32'h00000000;
			ien_r <= 5'h00;
		end else if (reg_write) begin
			case (reg_addr)
			`OFS_MODE: mode_r <= reg_wdata;
			`OFS_INPUT_CHANNEL_SELECT: input_channel_select_r <= reg_wdata[3:0];
			`OFS_CLKPWR: clkpwr_r <= reg_wdata[15:0];
			`OFS_TRG0: trg0_r <= reg_wdata;
			`OFS_TRG1: trg1_r <= reg_wdata;
			`OFS_TRG2: trg2_r <= reg_wdata;
			`OFS_BURST: slots_r <= reg_wdata;
			`OFS_IEN: ien_r <= reg_wdata[4:0];
			`OFS_COMPARE: compare_r <= reg_wdata;
			default: ien_r <= ien_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Start and stop bits; a fresh write beats the self-clear
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			start_r <= 1'b0;
			stop_r <= 1'b0;
		end else if (reg_write && reg_addr == `OFS_STARTSTOP) begin
			start_r <= reg_wdata[`SS_START] | (start_r & ~conv_tick);
			stop_r <= reg_wdata[`SS_STOP] | (stop_r & ~conv_tick);
		end else if (conv_tick) begin
			start_r <= 1'b0;
			stop_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// A trigger edge between two slow ticks waits for the next tick,
	// otherwise a divided conversion clock would lose most triggers
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			trig_pend_r <= 1'b0;
		else
			trig_pend_r <= (hw_ok && trigger_pulse) ||
				(trig_pend_r && !conv_tick);
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer, stepping on conversion clock ticks except for end of
	// conversion, which is caught at once so that a short pulse is not missed
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= S_IDLE;
			count_r <= 6'h00;
			wait_r <= 8'h00;
			step_r <= 3'h0;
			core_channel <= 4'h0;
			core_soc <= 1'b0;
			by_trigger_r <= 1'b0;
			stop_pend_r <= 1'b0;
		end else begin
			core_soc <= 1'b0;
			// Stop self-clears on the next tick, long before the running
			// conversion ends, so it is remembered here until then
			if (stop_r && state_r != S_IDLE)
				stop_pend_r <= 1'b1;
			case (state_r)
			S_IDLE: begin
				stop_pend_r <= 1'b0;
				if (conv_tick && go &&
					!clkpwr_r[`CP_PDOWN]) begin
					step_r <= 3'h0;
					by_trigger_r <= !start_r;
					core_channel <= is_burst ?
						slot_ch(slots_r, 3'h0) :
						input_channel_select_r;
					count_r <= 6'h00;
					state_r <= S_SAMPLE;
				end
			end
			S_WAIT: begin
				if (conv_tick) begin
					if (wait_r <= 8'h01) begin
						count_r <= 6'h00;
						state_r <= S_SAMPLE;
					end else
						wait_r <= wait_r - 8'h01;
				end
			end
			S_SAMPLE: begin
				if (conv_tick) begin
					if (count_r + 6'h01 >= sample_len) begin
						core_soc <= 1'b1;
						state_r <= S_CONV;
					end else
						count_r <= count_r + 6'h01;
				end
			end
			S_CONV: begin
				if (core_eoc)
					state_r <= S_NEXT;
			end
			S_NEXT: begin
				if (conv_tick) begin
					if (stop_r || stop_pend_r || !enabled ||
						(last_step && cmod != `CMOD_CONT)) begin
						state_r <= S_IDLE;
					end else begin
						count_r <= 6'h00;
						if (is_burst) begin
							step_r <= step_r + 3'h1;
							core_channel <= slot_ch(slots_r,
								step_r + 3'h1);
						end else
							core_channel <= input_channel_select_r;
						wait_r <= burst_wait_count;
						state_r <= (is_burst &&
							mode_r[`MODE_BURST_WAIT_COUNT_EN] &&
							burst_wait_count != 8'h00) ?
							S_WAIT : S_SAMPLE;
					end
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result capture and DMA request; request stays up until done returns
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			result_r <= {RES_W{1'b0}};
			rch_r <= 4'h0;
			dma_request <= 1'b0;
			dma_result_word <= 32'h00000000;
		end else begin
			if (state_r == S_CONV && core_eoc) begin
				result_r <= core_result;
				rch_r <= core_channel;
				if (mode_r[`MODE_DMA_TAG])
					dma_result_word <= {16'h0000, core_result,
						core_channel};
				else
					dma_result_word <= {12'h000, core_channel,
						core_result, 4'h0};
			end
			if (state_r == S_CONV && core_eoc && dma_en)
				dma_request <= 1'b1;
			else if (dma_done)
				dma_request <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags; hardware set wins over a software clear in one cycle
	wire eoc_now = (state_r == S_CONV) && core_eoc;
	wire [4:0] irq_set = {dma_done & dma_request,
		eoc_now & by_trigger_r,
		eoc_now & is_burst & last_step,
		eoc_now & (cmod == `CMOD_CONT),
		eoc_now & (cmod == `CMOD_SINGLE)};
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_r <= 5'h00;
			ovr_r <= 1'b0;
			trg_r <= 1'b0;
			end_r <= 1'b0;
		end else begin
			irq_r <= irq_set |
				(irq_r & ~(wr_status ? reg_wdata[4:0] : 5'h00));
			ovr_r <= (eoc_now & dma_request & ~dma_done) |
				(ovr_r & ~(wr_status & reg_wdata[5]));
			if (hw_ok && trigger_pulse)
				trg_r <= 1'b1;
			else if (eoc_now)
				trg_r <= 1'b0;
			if (eoc_now)
				end_r <= 1'b1;
			else if (state_r == S_IDLE && conv_tick && go)
				end_r <= 1'b0;
		end
	end

	// With DMA on only the done flag may raise the request
	assign conversion_irq = dma_en ? (irq_r[4] & ien_r[4]) :
		|(irq_r[3:0] & ien_r[3:0]);
	assign core_sample = (state_r == S_SAMPLE) ||
		(sts == `SAMPLE_ALWAYS);
	assign core_power_down = clkpwr_r[`CP_PDOWN];
	assign core_dac_disable = clkpwr_r[`CP_DAC_OFF];

	////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe; unmapped offsets read zero
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			reg_rdata <= 32'h00000000;
		else if (reg_read) begin
			case (reg_addr)
			`OFS_MODE: reg_rdata <= mode_r;
			`OFS_INPUT_CHANNEL_SELECT: reg_rdata <= {28'h0000000, input_channel_select_r};
			`OFS_CLKPWR: reg_rdata <= {16'h0000, clkpwr_r};
			`OFS_TRG0: reg_rdata <= trg0_r;
			`OFS_TRG1: reg_rdata <= trg1_r;
			`OFS_TRG2: reg_rdata <= trg2_r;
			`OFS_BURST: reg_rdata <= slots_r;
			`OFS_STARTSTOP: reg_rdata <= {27'h0000000, stop_r,
				3'h0, start_r};
			`OFS_STATUS: reg_rdata <= {16'h0000, core_channel,
				trg_r, step_r, end_r, state_r != S_IDLE,
				ovr_r, irq_r};
			`OFS_IEN: reg_rdata <= {27'h0000000, ien_r};
			`OFS_DMADATA: reg_rdata <= {16'h0000, result_r, rch_r};
			`OFS_COMPARE: reg_rdata <= compare_r;
			default: reg_rdata <= 32'h00000000;
			endcase
		end else
			reg_rdata <= 32'h00000000;
	end
endmodule // adc_conversion_control

// File: test/adc_ctrl_checker.sv
// Concurrent checks on the ports of the converter control unit
`timescale 1ns/100ps
module adc_ctrl_checker (
	// Clock and reset
	input wire clock,
	input wire reset_n,
	// Watched ports
	input wire reg_write,
	input wire core_soc,
	input wire core_sample,
	input wire [3:0] core_channel,
	input wire core_power_down,
	input wire core_eoc,
	input wire dma_request,
	input wire dma_done
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////////
	// Building blocks of the start and handshake steps
	sequence s_soc_pulse;
		core_soc ##1 !core_soc;
	endsequence
	sequence s_dma_wait;
		dma_request && !dma_done;
	endsequence
	sequence s_dma_ack;
		dma_request && dma_done && !core_eoc && !$past(core_eoc);
	endsequence
	////////////////////////////////////////////////////////////////////////
	AST_SOC_PULSE: assert property (core_soc |-> s_soc_pulse)
		else $error("soc longer than one cycle");
	// Two sampling cycles at least precede every start
	AST_SOC_SAMPLED: assert property (
		core_soc |-> $past(core_sample) && $past(core_sample, 2))
		else $error("soc without sampling");
	AST_CHAN_HELD: assert property (core_soc |=> $stable(core_channel))
		else $error("channel moved in conversion");
	AST_PD_NO_SOC: assert property (core_power_down |-> !core_soc)
		else $error("soc while powered down");
	AST_PD_WRITE: assert property (
		$changed(core_power_down) |-> $past(reg_write))
		else $error("power down moved without write");
	AST_DMA_HOLD: assert property (s_dma_wait |=> dma_request)
		else $error("dma request dropped early");
	AST_DMA_DROP: assert property (s_dma_ack |=> !dma_request)
		else $error("dma request kept after done");
	AST_DMA_CAUSE: assert property (
		$rose(dma_request) |-> $past(core_eoc) || $past(core_eoc, 2))
		else $error("dma request without eoc");
endmodule // adc_ctrl_checker

bind adc_conversion_control adc_ctrl_checker chk_i (
	.clock(clock),
	.reset_n(reset_n),
	.reg_write(reg_write),
	.core_soc(core_soc),
	.core_sample(core_sample),
	.core_channel(core_channel),
	.core_power_down(core_power_down),
	.core_eoc(core_eoc),
	.dma_request(dma_request),
	.dma_done(dma_done)
);

// File: test/conv_core_model.sv
// Behavioural analog core that converts once per start pulse
`timescale 1ns/100ps
module conv_core_model (
	// Clock and reset
	input wire clock,
	input wire reset_n,
	// From the sequencer
	input wire [3:0] core_channel,
	input wire core_soc,
	input wire slow,
	// To the sequencer
	output reg core_eoc,
	output reg [11:0] core_result
);
	reg [3:0] cnt_r;
	reg [3:0] ch_r;
	reg busy_r;
	// Result is valid in the eoc cycle only; it toggles otherwise so
	// that a late capture cannot match by luck
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			core_eoc <= 1'b0;
			core_result <= 12'h000;
			cnt_r <= 4'h0;
			ch_r <= 4'h0;
			busy_r <= 1'b0;
		end else begin
			core_eoc <= 1'b0;
			core_result <= ~core_result;
			if (core_soc) begin
				busy_r <= 1'b1;
				ch_r <= core_channel;
				cnt_r <= slow ? 4'h9 : 4'h2;
			end else if (busy_r && cnt_r == 4'h0) begin
				busy_r <= 1'b0;
				core_eoc <= 1'b1;
				core_result <= {ch_r, 8'h3C};
			end else if (busy_r) begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end
endmodule // conv_core_model

// File: test/adc_conversion_control_tb_top.sv
// Self-checking bench of the converter control unit
`timescale 1ns/100ps
`include "adc_ctrl_defs.vh"
module adc_conversion_control_tb_top;
	localparam [31:0] EN = 32'h00000080;
	localparam [31:0] DMA = 32'h00020000;
	localparam [31:0] TAG = 32'h00010000;
	localparam [31:0] TEN = 32'h00000008;
	localparam [31:0] GO = 32'h00000001;
	reg clock = 1'b0;
	reg reset_n = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg [31:0] reg_wdata = 32'h00000000;
	reg reg_write = 1'b0;
	reg reg_read = 1'b0;
	reg ext_clock_pin = 1'b0;
	reg [5:0] trigger_in = 6'h00;
	reg dma_done = 1'b0;
	reg slow = 1'b0;
	reg rp = 1'b0;
	reg [1:0] dd = 2'h0;
	reg [31:0] rng = 32'h0000A322;
	reg [31:0] s;
	reg [3:0] ch;
	reg [3:0] sch;
	reg [11:0] r;
	reg [31:0] rq[$];
	reg [31:0] dq[$];
	int num_errors = 0;
	int check_count = 0;
	int a, b, c, d, n, i, k;
	wire [31:0] reg_rdata, dma_result_word;
	wire [3:0] core_channel;
	wire [11:0] core_result;
	wire core_sample, core_soc, core_power_down, core_dac_disable;
	wire core_conv_clk, core_eoc, dma_request, conversion_irq;
	adc_conversion_control DUT (.clock(clock), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata),
		.ext_clock_pin(ext_clock_pin), .trigger_in(trigger_in),
		.core_channel(core_channel), .core_sample(core_sample),
		.core_soc(core_soc), .core_power_down(core_power_down),
		.core_dac_disable(core_dac_disable), .core_conv_clk(core_conv_clk),
		.core_eoc(core_eoc), .core_result(core_result),
		.dma_request(dma_request), .dma_done(dma_done),
		.dma_result_word(dma_result_word), .conversion_irq(conversion_irq));
	conv_core_model core_i (.clock(clock), .reset_n(reset_n),
		.core_channel(core_channel), .core_soc(core_soc), .slow(slow),
		.core_eoc(core_eoc), .core_result(core_result));
	////////////////////////////////////////////////////////////////////////
	// Clock, and an external pin toggling every five clocks
	always #10 clock = ~clock;
	always begin
		repeat(5) @(posedge clock);
		ext_clock_pin <= ~ext_clock_pin;
	end
	// DMA controller: done two cycles after it notices a request
	always @(posedge clock) begin
		dd <= {dd[0], dma_request & ~|dd & ~dma_done};
		dma_done <= dd[1];
	end
	// Watcher takes the oldest note whenever a result appears
	always @(posedge clock) begin
		rp <= reg_read;
		if (rp)
			chk(reg_rdata, rq.size() ? rq.pop_front() : {32{1'bx}});
		if (dma_request & ~|dd & ~dma_done)
			chk(dma_result_word, dq.size() ? dq.pop_front() : {32{1'bx}});
	end
	////////////////////////////////////////////////////////////////////////
	function automatic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task chk(input [31:0] g, input [31:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input [7:0] ad, input [31:0] v);
		@(posedge clock);
		reg_addr <= ad;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task rd(input [7:0] ad, input [31:0] e);
		rq.push_back(e);
		@(posedge clock);
		reg_addr <= ad;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
	endtask
	// Waits for m start pulses and returns the cycles spent
	task ws(input int m, output int t);
		t = 0;
		while (m > 0 && t < 3000) begin
			@(posedge clock) #1;
			t++;
			if (core_soc === 1'b1) begin
				m--;
				sch = core_channel;
			end
		end
		chk(m, 0);
	endtask
	// Counts starts over a quiet spell; more than m is wrong
	task quiet(input int m);
		n = 0;
		repeat(150) begin
			@(posedge clock) #1;
			if (core_soc !== 1'b0)
				n++;
		end
		chk(32'(n > m), 0);
	endtask
	task pulse(input [5:0] p);
		@(posedge clock);
		trigger_in <= p;
		repeat(4) @(posedge clock);
		trigger_in <= 6'h00;
	endtask
	task lat(input [31:0] cp, output int t);
		wr(`OFS_CLKPWR, cp);
		wr(`OFS_STARTSTOP, GO);
		ws(1, t);
		repeat(40) @(posedge clock);
	endtask
	task duty(input [31:0] cp, output int h);
		wr(`OFS_CLKPWR, cp);
		h = 0;
		repeat(50) begin
			@(posedge clock) #1;
			h += core_conv_clk;
		end
	endtask
	task end_sim();
		if (num_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat(6) @(posedge clock);
		reset_n <= 1'b1;
		for (i = 0; i < 12; i++)
			rd(i * 4, i == 2 ? 32'h00000080 : 32'h0);
		s = xs();
		ch = s[3:0];
		wr(`OFS_BURST, s);
		rd(`OFS_BURST, s);
		wr(`OFS_DMADATA, s);
		rd(`OFS_DMADATA, 32'h0);
		wr(`OFS_MODE, EN);
		wr(`OFS_INPUT_CHANNEL_SELECT, {28'h0, ch});
		lat(32'h0, a);
		lat(32'h5, b);
		chk(b - a, 5);
		chk({28'h0, sch}, {28'h0, ch});
		lat(32'h400, c);
		lat(32'h405, d);
		chk(32'(d - c > 16 && d - c < 24), 1);
		lat(32'h40, c);
		lat(32'h45, d);
		chk(32'(d - c > 40 && d - c < 60), 1);
		duty(32'h500, a);
		duty(32'h520, b);
		chk(32'(a > 25 && b < 25), 1);
		wr(`OFS_CLKPWR, 32'h0);
		r = {ch, 8'h3C};
		for (k = 0; k < 2; k++) begin
			slow <= k[0];
			wr(`OFS_MODE, EN | DMA | (k ? TAG : 32'h0));
			dq.push_back(k ? {16'h0, r, ch} : {12'h0, ch, r, 4'h0});
			wr(`OFS_STARTSTOP, GO);
			repeat(60) @(posedge clock);
			rd(`OFS_DMADATA, {16'h0, r, ch});
		end
		slow <= 1'b0;
		for (k = 0; k < 2; k++) begin
			wr(`OFS_MODE, EN | DMA | TAG | 32'h330 | (k ? 32'h03001000 : 0));
			for (i = 0; i < 4; i++)
				dq.push_back({16'h0, s[4*i+:4], 8'h3C, s[4*i+:4]});
			wr(`OFS_STARTSTOP, GO);
			ws(4, c);
			if (k)
				chk(c - a, 9);
			a = c;
			repeat(60) @(posedge clock);
		end
		for (k = 0; k < 6; k++) begin
			wr(`OFS_MODE, EN | TEN | k);
			pulse(6'h01 << ((k + 1) % 6));
			quiet(0);
			pulse(6'h01 << k);
			ws(1, a);
			repeat(40) @(posedge clock);
		end
		for (k = 6; k < 8; k++) begin
			wr(`OFS_MODE, EN | TEN | k);
			pulse(6'h3F);
			quiet(0);
		end
		wr(`OFS_MODE, EN | TEN | 32'h10);
		pulse(6'h3F);
		quiet(0);
		wr(`OFS_MODE, EN | 32'h20);
		wr(`OFS_STARTSTOP, GO);
		quiet(0);
		wr(`OFS_MODE, 32'h0);
		wr(`OFS_STARTSTOP, GO);
		quiet(0);
		wr(`OFS_MODE, EN);
		wr(`OFS_CLKPWR, 32'h80);
		wr(`OFS_STARTSTOP, GO);
		quiet(0);
		wr(`OFS_CLKPWR, 32'h0);
		wr(`OFS_MODE, EN | 32'h10);
		wr(`OFS_INPUT_CHANNEL_SELECT, {28'h0, ~ch});
		wr(`OFS_STARTSTOP, GO);
		ws(2, a);
		chk({28'h0, sch}, {28'h0, ~ch});
		wr(`OFS_STARTSTOP, 32'h10);
		quiet(1);
		// Interrupt waits for DMA done when DMA is on, else follows the flag
		wr(`OFS_STATUS, 32'h3F);
		wr(`OFS_IEN, 32'h11);
		wr(`OFS_MODE, EN | DMA | TAG);
		dq.push_back({16'h0, ~ch, 8'h3C, ~ch});
		wr(`OFS_STARTSTOP, GO);
		ws(1, a);
		repeat(7) @(posedge clock);
		#1 chk({31'h0, conversion_irq}, 0);
		repeat(5) @(posedge clock);
		#1 chk({31'h0, conversion_irq}, 1);
		wr(`OFS_STATUS, 32'h3F);
		#1 chk({31'h0, conversion_irq}, 0);
		wr(`OFS_MODE, EN);
		wr(`OFS_STARTSTOP, GO);
		ws(1, a);
		repeat(8) @(posedge clock);
		#1 chk({31'h0, conversion_irq}, 1);
		wr(`OFS_CLKPWR, 32'h8080);
		#1 chk({30'h0, core_dac_disable, core_power_down}, 3);
		wr(`OFS_MODE, EN);
		wr(`OFS_CLKPWR, 32'h100);
		wr(`OFS_STARTSTOP, GO);
		quiet(0);
		end_sim();
	end
	// Watchdog well beyond the expected run length
	initial begin
		#1500000;
		num_errors++;
		end_sim();
	end
endmodule // adc_conversion_control_tb_top
